//--- logic/dvp_top.sv
// Displacement value pipeline: peak search, linearization, averaging, settings
`timescale 1ns/1ps
module dvp_top #(
  parameter int CYCLE_DIV = dvp_pkg::DIV_DEF,
  parameter int DEPTH     = dvp_pkg::FIFO_DEPTH
) (
  input  wire logic                        clock,
  input  wire logic                        reset,
  input  wire logic [7:0]                  addr,
  input  wire logic [31:0]                 wdata,
  input  wire logic                        wrEn,
  input  wire logic                        rdEn,
  output logic [31:0]                      rdata,
  input  wire logic [7:0]                  webAddr,
  input  wire logic [31:0]                 webData,
  input  wire logic                        webWr,
  input  wire logic                        pixValid,
  input  wire logic [7:0]                  pixData,
  input  wire logic                        trigIn,
  output logic                             nvRead,
  output logic                             nvWrite,
  output logic [31:0]                      nvWData,
  input  wire logic [31:0]                 nvRData,
  input  wire logic                        nvValid,
  input  wire logic                        nvDone,
  output logic                             outValid,
  output logic [dvp_pkg::DIST_W-1:0]       outData,
  input  wire logic                        outReady
);
  if (CYCLE_DIV < dvp_pkg::DIV_MIN || CYCLE_DIV > 65535) begin : g_div_check
    $error("CYCLE_DIV out of range");
  end
  typedef enum logic [3:0] {ST_BOOT = 4'h1, ST_LOAD = 4'h2, ST_RUN = 4'h4, ST_SAVE = 4'h8} dvp_st_t;
  dvp_st_t           state_reg;
  dvp_pkg::dvp_cfg_t cfg_reg;
  dvp_pkg::dvp_cfg_t cfgAct_reg;
  dvp_pkg::dvp_wreq_t webHold_reg;
  logic              webPend_reg;
  logic [15:0]       div_reg;
  logic [15:0]       divAct_reg;
  logic [15:0]       cnt_reg;
  logic              tick;
  logic              saveReq_reg;
  logic              wrAny;
  dvp_pkg::dvp_wreq_t wr;
  // Peak search state
  logic [dvp_pkg::PIX_W-1:0] pix_reg;
  logic [dvp_pkg::PIX_W-1:0] pkPos_reg;
  logic [7:0]        pkVal_reg;
  logic              pkFound_reg;
  logic              inWin;
  logic              trigPrev_reg;
  logic              trigArm_reg;
  logic              emitNow;
  // Pipeline stages
  dvp_pkg::dvp_smp_t s1_reg;
  dvp_pkg::dvp_smp_t s2_reg;
  dvp_pkg::dvp_smp_t s3_reg;
  dvp_pkg::dvp_smp_t s3_next;
  logic [dvp_pkg::DIST_W-1:0] hist [dvp_pkg::AVG_LONG];
  logic [6:0]        hPtr_reg;
  logic [22:0]       sumL_reg;
  logic [22:0]       sumS_reg;
  logic [dvp_pkg::DIST_W-1:0] medWin [dvp_pkg::MED_LEN];
  logic [7:0]        dropCnt_reg;
  logic              fifoReady;
  logic              fifoValid;
  logic [dvp_pkg::DIST_W-1:0] fifoData;
  logic              fifoPop;

  // Non-linear position to distance curve, near end at pixel 0
  function automatic logic [dvp_pkg::DIST_W-1:0] linearize(input logic [dvp_pkg::PIX_W-1:0] p);
    logic [31:0] q;
    q = 32'(p) * 32'(dvp_pkg::LIN_GAIN) + ((32'(p) * 32'(p)) >> dvp_pkg::LIN_SQ_SH);
    return q[dvp_pkg::DIST_W-1:0];
  endfunction : linearize

  // Median by rank counting
  function automatic logic [dvp_pkg::DIST_W-1:0] median9(input logic [dvp_pkg::DIST_W-1:0] w [dvp_pkg::MED_LEN]);
    logic [dvp_pkg::DIST_W-1:0] m;
    int lt;
    int le;
    m = w[0];
    for (int i = 0; i < dvp_pkg::MED_LEN; i++) begin
      lt = 0;
      le = 0;
      for (int j = 0; j < dvp_pkg::MED_LEN; j++) begin
        if (w[j] < w[i]) lt++;
        if (w[j] <= w[i]) le++;
      end
      if (lt <= dvp_pkg::MED_LEN / 2 && le > dvp_pkg::MED_LEN / 2) m = w[i];
    end
    return m;
  endfunction : median9

  // Cycle divider
  assign tick = cnt_reg == divAct_reg - 16'h0001;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_reg <= 16'h0000;
    end else if (tick) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // Write merge of serial and browser paths
  assign wrAny = wrEn || webPend_reg || webWr;
  always_comb begin
    if (wrEn) wr = '{addr, wdata};
    else if (webPend_reg) wr = webHold_reg;
    else wr = '{webAddr, webData};
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      webPend_reg <= 1'b0;
      webHold_reg <= '0;
    end else if (wrEn && webWr) begin
      webPend_reg <= 1'b1;
      webHold_reg <= '{webAddr, webData};
    end else if (!wrEn) begin
      webPend_reg <= webPend_reg && webWr;
      if (webPend_reg && webWr) webHold_reg <= '{webAddr, webData};
    end
  end

  // Settings, boot restore and save
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg   <= ST_BOOT;
      cfg_reg     <= dvp_pkg::CFG_DEFAULT;
      div_reg     <= 16'(CYCLE_DIV);
      saveReq_reg <= 1'b0;
      nvRead      <= 1'b0;
      nvWrite     <= 1'b0;
      nvWData     <= 32'h00000000;
    end else begin
      nvRead  <= 1'b0;
      nvWrite <= 1'b0;
      case (state_reg)
        ST_BOOT: begin
          nvRead    <= 1'b1;
          state_reg <= ST_LOAD;
        end
        ST_LOAD: begin
          if (nvDone) begin
            if (nvValid) cfg_reg <= dvp_pkg::dvp_cfg_t'(nvRData);
            else cfg_reg <= dvp_pkg::presetCfg(dvp_pkg::CFG_DEFAULT, dvp_pkg::PRE_STD);
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (saveReq_reg) begin
            nvWrite     <= 1'b1;
            nvWData     <= 32'(cfg_reg);
            saveReq_reg <= 1'b0;
            state_reg   <= ST_SAVE;
          end else if (wrAny) begin
            case (wr.addr)
              dvp_pkg::OFS_CTRL: begin
                cfg_reg.avg      <= dvp_pkg::dvp_avg_t'(wr.data[dvp_pkg::CTRL_AVG_LSB +: 2]);
                cfg_reg.trigEn   <= wr.data[dvp_pkg::CTRL_TRIG_EN];
                cfg_reg.trigEdge <= wr.data[dvp_pkg::CTRL_TRIG_EDG];
              end
              dvp_pkg::OFS_PRESET: cfg_reg <= dvp_pkg::presetCfg(cfg_reg, wr.data[1:0]);
              dvp_pkg::OFS_RATE: begin
                if (wr.data[15:0] < 16'(dvp_pkg::DIV_MIN)) div_reg <= 16'(dvp_pkg::DIV_MIN);
                else div_reg <= wr.data[15:0];
              end
              dvp_pkg::OFS_MASK: begin
                cfg_reg.maskL <= wr.data[dvp_pkg::PIX_W-1:0];
                cfg_reg.maskR <= wr.data[dvp_pkg::MASK_R_LSB +: dvp_pkg::PIX_W];
              end
              dvp_pkg::OFS_SAVE: saveReq_reg <= wr.data[0];
              default: ;
            endcase
          end
        end
        ST_SAVE: begin
          if (nvDone) state_reg <= ST_RUN;
        end
        default: state_reg <= ST_BOOT;
      endcase
    end
  end

  // Active settings change only at a cycle boundary
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cfgAct_reg <= dvp_pkg::CFG_DEFAULT;
      divAct_reg <= 16'(CYCLE_DIV);
    end else if (tick) begin
      cfgAct_reg <= cfg_reg;
      divAct_reg <= div_reg;
    end
  end

  // Register reads
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata <= 32'h00000000;
    end else if (rdEn) begin
      case (addr)
        dvp_pkg::OFS_CTRL: rdata <= {28'h0000000, cfg_reg.trigEdge, cfg_reg.trigEn, cfg_reg.avg};
        dvp_pkg::OFS_PRESET: rdata <= {24'h000000, cfg_reg.thresh};
        dvp_pkg::OFS_RATE: rdata <= {16'h0000, div_reg};
        dvp_pkg::OFS_MASK: rdata <= {7'h00, cfg_reg.maskR, 7'h00, cfg_reg.maskL};
        dvp_pkg::OFS_STATUS: rdata <= {16'h0000, dropCnt_reg, 3'h0, s3_reg.found, state_reg};
        dvp_pkg::OFS_LAST: rdata <= {16'h0000, s3_reg.value};
        default: rdata <= 32'h00000000;
      endcase
    end
  end

  // Peak search over the profile of the running cycle
  assign inWin = pix_reg >= dvp_pkg::PIX_W'(dvp_pkg::LIN_LO) && pix_reg <= dvp_pkg::PIX_W'(dvp_pkg::LIN_HI)
               && pix_reg >= cfgAct_reg.maskL && pix_reg <= cfgAct_reg.maskR;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pix_reg     <= '0;
      pkPos_reg   <= '0;
      pkVal_reg   <= 8'h00;
      pkFound_reg <= 1'b0;
    end else if (tick) begin
      pix_reg     <= '0;
      pkVal_reg   <= 8'h00;
      pkFound_reg <= 1'b0;
    end else if (pixValid) begin
      pix_reg <= pix_reg + 1'b1;
      if (inWin && pixData >= cfgAct_reg.thresh) begin
        if (!pkFound_reg || cfgAct_reg.peakSel == dvp_pkg::PK_LAST
            || (cfgAct_reg.peakSel == dvp_pkg::PK_MAX && pixData > pkVal_reg)) begin
          pkPos_reg <= pix_reg;
          pkVal_reg <= pixData;
        end
        pkFound_reg <= 1'b1;
      end
    end
  end

  // Trigger gating of output start
  assign emitNow = !cfgAct_reg.trigEn || (cfgAct_reg.trigEdge ? trigArm_reg : trigIn);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      trigPrev_reg <= 1'b1; // Idle level of the pulled-up input
      trigArm_reg  <= 1'b0;
    end else begin
      trigPrev_reg <= trigIn;
      if (trigIn && !trigPrev_reg) trigArm_reg <= 1'b1;
      else if (tick) trigArm_reg <= 1'b0;
    end
  end

  // Averaging stage input window
  always_comb begin
    medWin[0] = s2_reg.value;
    for (int k = 1; k < dvp_pkg::MED_LEN; k++) begin
      medWin[k] = hist[7'(hPtr_reg - 7'(k))];
    end
  end
  always_comb begin
    s3_next = s2_reg;
    case (cfgAct_reg.avg)
      dvp_pkg::AVG_STATIC: s3_next.value = 16'((sumL_reg + 23'(s2_reg.value) - 23'(hist[hPtr_reg])) >> 7);
      dvp_pkg::AVG_BAL: s3_next.value = 16'((sumS_reg + 23'(s2_reg.value) - 23'(hist[7'(hPtr_reg - 7'h40)])) >> 6);
      dvp_pkg::AVG_DYN: s3_next.value = median9(medWin);
      default: s3_next.value = s2_reg.value;
    endcase
  end

  // Three stages advance together on each cycle tick
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else if (tick) begin
      s1_reg <= '{pkFound_reg, emitNow, {7'h00, pkPos_reg}};
      s2_reg <= '{s1_reg.found, s1_reg.emit, linearize(s1_reg.value[dvp_pkg::PIX_W-1:0])};
      s3_reg <= s3_next;
    end
  end

  // History for the moving filters
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int k = 0; k < dvp_pkg::AVG_LONG; k++) hist[k] <= '0;
    end else if (tick && s2_reg.found) begin
      hist[hPtr_reg] <= s2_reg.value;
    end
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hPtr_reg <= 7'h00;
      sumL_reg <= 23'h000000;
      sumS_reg <= 23'h000000;
    end else if (tick && s2_reg.found) begin
      hPtr_reg <= hPtr_reg + 7'h01;
      sumL_reg <= sumL_reg + 23'(s2_reg.value) - 23'(hist[hPtr_reg]);
      sumS_reg <= sumS_reg + 23'(s2_reg.value) - 23'(hist[7'(hPtr_reg - 7'h40)]);
    end
  end

  // Result buffer and registered output
  dvp_fifo #(.W(dvp_pkg::DIST_W), .D(DEPTH)) u_fifo (
    .clock    (clock),
    .reset    (reset),
    .inValid  (tick && s3_reg.found && s3_reg.emit),
    .inReady  (fifoReady),
    .inData   (s3_reg.value),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );
  assign fifoPop = !outValid || outReady;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      outValid    <= 1'b0;
      outData     <= '0;
      dropCnt_reg <= 8'h00;
    end else begin
      if (fifoPop) begin
        outValid <= fifoValid;
        outData  <= fifoData;
      end
      if (tick && s3_reg.found && s3_reg.emit && !fifoReady && dropCnt_reg != 8'hFF) begin
        dropCnt_reg <= dropCnt_reg + 8'h01;
      end
    end
  end

  // Checks
  a_rate_floor: assert property (@(posedge clock) disable iff (reset) divAct_reg >= 16'(dvp_pkg::DIV_MIN))
    else $error("cycle faster than maximum rate");
  a_tick_period: assert property (@(posedge clock) disable iff (reset)
    tick && divAct_reg == $past(divAct_reg) |-> $past(cnt_reg) == divAct_reg - 16'h0002)
    else $error("cycle period mismatch");
  a_stage_shift: assert property (@(posedge clock) disable iff (reset)
    tick |=> s2_reg.value == linearize($past(s1_reg.value[dvp_pkg::PIX_W-1:0])) && s3_reg.found == $past(s2_reg.found))
    else $error("stages did not advance together");
  a_peak_window: assert property (@(posedge clock) disable iff (reset)
    tick && pkFound_reg |-> pkPos_reg >= dvp_pkg::PIX_W'(dvp_pkg::LIN_LO) && pkPos_reg <= dvp_pkg::PIX_W'(dvp_pkg::LIN_HI)
      && pkPos_reg >= cfgAct_reg.maskL && pkPos_reg <= cfgAct_reg.maskR)
    else $error("peak outside evaluated range");
  a_cfg_boundary: assert property (@(posedge clock) disable iff (reset) !$past(tick) |-> $stable(cfgAct_reg))
    else $error("active settings changed mid cycle");
  a_preset_group: assert property (@(posedge clock) disable iff (reset)
    state_reg == ST_RUN && !saveReq_reg && wrEn && addr == dvp_pkg::OFS_PRESET && wdata[1:0] == 2'h1
      |=> cfg_reg.avg == dvp_pkg::AVG_DYN && cfg_reg.peakSel == dvp_pkg::PK_FIRST)
    else $error("preset group not loaded");
  a_save_write: assert property (@(posedge clock) disable iff (reset)
    state_reg == ST_RUN && saveReq_reg |=> nvWrite && nvWData == 32'($past(cfg_reg)) ##1 !nvWrite)
    else $error("save did not write settings");
  a_boot_default: assert property (@(posedge clock) disable iff (reset)
    state_reg == ST_LOAD && nvDone && !nvValid |=> cfg_reg.avg == dvp_pkg::AVG_BAL && state_reg == ST_RUN)
    else $error("standard preset not applied");
  a_avg_bypass: assert property (@(posedge clock) disable iff (reset)
    tick && cfgAct_reg.avg == dvp_pkg::AVG_NONE |=> s3_reg.value == $past(s2_reg.value))
    else $error("bypass altered value");
  a_trig_hold: assert property (@(posedge clock) disable iff (reset)
    tick && cfgAct_reg.trigEn && !cfgAct_reg.trigEdge && !trigIn |=> !s1_reg.emit)
    else $error("emit without trigger");
endmodule : dvp_top

//--- common/dvp_pkg.sv
// Constants, types and presets of the displacement value pipeline
package dvp_pkg;
  localparam int CLK_HZ      = 20000000;
  localparam int RATE_MAX_HZ = 4000;
  localparam int RATE_DEF_HZ = 1000;
  localparam int DIV_MIN     = CLK_HZ / RATE_MAX_HZ;
  localparam int DIV_DEF     = CLK_HZ / RATE_DEF_HZ;
  localparam int PIX_W       = 9;
  localparam int DIST_W      = 16;
  localparam int LIN_LO      = 32;
  localparam int LIN_HI      = 479;
  localparam int LIN_GAIN    = 64;
  localparam int LIN_SQ_SH   = 3;
  localparam int AVG_LONG    = 128;
  localparam int AVG_SHORT   = 64;
  localparam int MED_LEN     = 9;
  localparam int FIFO_DEPTH  = 16;
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PRESET = 8'h04;
  localparam logic [7:0] OFS_RATE   = 8'h08;
  localparam logic [7:0] OFS_MASK   = 8'h0C;
  localparam logic [7:0] OFS_SAVE   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_LAST   = 8'h18;
  localparam int CTRL_AVG_LSB  = 0;
  localparam int CTRL_TRIG_EN  = 2;
  localparam int CTRL_TRIG_EDG = 3;
  localparam int MASK_R_LSB    = 16;
  typedef enum logic [1:0] {AVG_STATIC = 2'h0, AVG_BAL = 2'h1, AVG_DYN = 2'h2, AVG_NONE = 2'h3} dvp_avg_t;
  typedef enum logic [1:0] {PRE_STD = 2'h0, PRE_MULTI = 2'h1, PRE_PEN = 2'h2} dvp_pre_t;
  typedef enum logic [1:0] {PK_MAX = 2'h0, PK_FIRST = 2'h1, PK_LAST = 2'h2} dvp_pk_t;
  typedef struct packed {
    dvp_avg_t         avg;
    dvp_pk_t          peakSel;
    logic [7:0]       thresh;
    logic             trigEn;
    logic             trigEdge;
    logic [PIX_W-1:0] maskL;
    logic [PIX_W-1:0] maskR;
  } dvp_cfg_t;
  typedef struct packed {
    logic              found;
    logic              emit;
    logic [DIST_W-1:0] value;
  } dvp_smp_t;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
  } dvp_wreq_t;
  localparam dvp_cfg_t CFG_DEFAULT = '{AVG_BAL, PK_MAX, 8'h20, 1'b0, 1'b0, 9'h000, 9'h1FF};
  // Whole setting group of one material preset
  function automatic dvp_cfg_t presetCfg(input dvp_cfg_t cur, input logic [1:0] sel);
    dvp_cfg_t c;
    c = cur;
    case (sel)
      PRE_MULTI: begin c.avg = AVG_DYN;  c.peakSel = PK_FIRST; c.thresh = 8'h30; end
      PRE_PEN:   begin c.avg = AVG_BAL;  c.peakSel = PK_LAST;  c.thresh = 8'h18; end
      default:   begin c.avg = AVG_BAL;  c.peakSel = PK_MAX;   c.thresh = 8'h20; end
    endcase
    return c;
  endfunction : presetCfg
endpackage : dvp_pkg

//--- logic/dvp_fifo.sv
// Result FIFO with valid and ready on both sides
`timescale 1ns/1ps
module dvp_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(D);
  if (D < 2 || (1 << AW) != D) begin : g_depth_check
    $error("Depth must be a power of two");
  end
  logic [W-1:0] mem [D];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0]   count_reg;
  logic          push;
  logic          pop;
  assign inReady  = count_reg != (AW+1)'(D);
  assign outValid = count_reg != '0;
  assign outData  = mem[rdPtr_reg];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wrPtr_reg <= wrPtr_reg + 1'b1;
      if (pop) rdPtr_reg <= rdPtr_reg + 1'b1;
      if (push && !pop) count_reg <= count_reg + 1'b1;
      else if (pop && !push) count_reg <= count_reg - 1'b1;
    end
  end
endmodule : dvp_fifo

//--- verif/dvp_nv_model.sv
// Behavioural non-volatile settings store facing the pipeline
`timescale 1ns/1ps
module dvp_nv_model #(
  parameter int LAT = 3
) (
  input  wire logic        clock,
  input  wire logic        nvRead,
  input  wire logic        nvWrite,
  input  wire logic [31:0] nvWData,
  output logic [31:0]      nvRData,
  output logic             nvValid,
  output logic             nvDone
);
  logic [31:0] storeReg;
  int          waitCnt;
  initial begin
    storeReg = 32'h00000000;
    nvValid  = 1'b0;
    nvDone   = 1'b0;
    nvRData  = 32'hFFFFFFFF;
    waitCnt  = 0;
  end
  // Contents survive the pipeline reset; answers come LAT clocks late
  always @(posedge clock) begin
    nvDone  <= 1'b0;
    nvRData <= ~storeReg;
    if (nvWrite) begin
      storeReg <= nvWData;
      nvValid  <= 1'b1;
      waitCnt  <= LAT;
    end else if (nvRead) begin
      waitCnt <= LAT;
    end else if (waitCnt == 1) begin
      nvDone  <= 1'b1;
      nvRData <= storeReg;
      waitCnt <= 0;
    end else if (waitCnt > 1) begin
      waitCnt <= waitCnt - 1;
    end
  end
endmodule : dvp_nv_model

//--- verif/tb_dvp_top.sv
// Self-checking bench of the displacement value pipeline
`timescale 1ns/1ps
module tb_dvp_top;
  localparam int DIV = 5000;
  localparam int PIX = 100;
  localparam int VAL = PIX * dvp_pkg::LIN_GAIN + ((PIX * PIX) >> dvp_pkg::LIN_SQ_SH);
  localparam int LO   = dvp_pkg::LIN_LO;
  localparam int VAL0 = LO * dvp_pkg::LIN_GAIN + ((LO * LO) >> dvp_pkg::LIN_SQ_SH);
  logic                       clock;
  logic                       reset;
  logic [7:0]                 addr;
  logic [31:0]                wdata;
  logic                       wrEn;
  logic                       rdEn;
  logic [31:0]                rdata;
  logic [7:0]                 webAddr;
  logic [31:0]                webData;
  logic                       webWr;
  logic                       nvRead;
  logic                       nvWrite;
  logic [31:0]                nvWData;
  logic [31:0]                nvRData;
  logic                       nvValid;
  logic                       nvDone;
  logic                       outValid;
  logic [dvp_pkg::DIST_W-1:0] outData;
  logic                       outReady;
  int                         error_cnt;
  int                         compares;
  int                         n;
  logic                       got;
  logic [31:0]                v;
  logic [dvp_pkg::DIST_W-1:0] d;
  longint                     tLast;
  longint                     tGap;
  dvp_pkg::dvp_cfg_t          cfg;
  logic [7:0]                 preThr [3] = '{8'h20, 8'h30, 8'h18};
  logic [1:0]                 preAvg [3] = '{2'h1, 2'h2, 2'h1};
  dvp_top #(.CYCLE_DIV(DIV), .DEPTH(16)) dvp_top_i (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata),
    .wrEn(wrEn), .rdEn(rdEn), .rdata(rdata), .webAddr(webAddr), .webData(webData), .webWr(webWr),
    .pixValid(1'b1), .pixData(8'hFF), .trigIn(1'b0), .nvRead(nvRead), .nvWrite(nvWrite), .nvWData(nvWData),
    .nvRData(nvRData), .nvValid(nvValid), .nvDone(nvDone), .outValid(outValid), .outData(outData),
    .outReady(outReady));
  dvp_nv_model #(.LAT(3)) dvp_nv_model_i (.clock(clock), .nvRead(nvRead), .nvWrite(nvWrite),
    .nvWData(nvWData), .nvRData(nvRData), .nvValid(nvValid), .nvDone(nvDone));
  always #25 clock = ~clock;
  task automatic conclude;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge clock);
    addr  <= a;
    wdata <= dat;
    wrEn  <= 1'b1;
    @(posedge clock);
    wrEn  <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] dat);
    @(posedge clock);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clock);
    rdEn <= 1'b0;
    #1 dat = rdata;
  endtask : rd
  task automatic waitRun;
    logic [31:0] s;
    s = 32'h0;
    for (int i = 0; i < 100 && s[3:0] !== 4'h4; i++) rd(dvp_pkg::OFS_STATUS, s);
    if (s[3:0] !== 4'h4) begin
      error_cnt++;
      conclude();
    end
  endtask : waitRun
  // Next accepted result; a missing one is fatal only when must is set
  task automatic getOut(input logic must);
    got = 1'b0;
    for (int i = 0; i < 2 * DIV + 100 && !got; i++) begin
      @(posedge clock);
      got = (outValid === 1'b1 && outReady === 1'b1);
    end
    if (must && !got) begin
      error_cnt++;
      conclude();
    end else begin
      d     = outData;
      tGap  = $time / 50 - tLast;
      tLast = $time / 50;
    end
  endtask : getOut
  initial begin
    clock = 1'b0; reset = 1'b1; addr = 8'h00; wdata = 32'h0; wrEn = 1'b0; rdEn = 1'b0;
    webAddr = 8'h00; webData = 32'h0; webWr = 1'b0; outReady = 1'b1;
    error_cnt = 0; compares = 0; tLast = 0;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    waitRun();
    rd(dvp_pkg::OFS_PRESET, v); check(v, 32'h20);
    rd(dvp_pkg::OFS_CTRL, v); check(v, 32'h1);
    rd(dvp_pkg::OFS_MASK, v); check(v, 32'h01FF0000);
    for (n = 1; n < 4; n++) begin
      wr(dvp_pkg::OFS_PRESET, 32'(n % 3));
      rd(dvp_pkg::OFS_PRESET, v); check(v, 32'(preThr[n % 3]));
      rd(dvp_pkg::OFS_CTRL, v); check(v[1:0], 32'(preAvg[n % 3]));
    end
    wr(dvp_pkg::OFS_RATE, 32'd100); rd(dvp_pkg::OFS_RATE, v); check(v, 32'd5000);
    wr(8'h1C, 32'hFFFFFFFF); rd(8'h1C, v); check(v, 32'h0);
    // Serial and browser writes in the same cycle
    @(posedge clock);
    addr <= dvp_pkg::OFS_CTRL; wdata <= 32'h1; wrEn <= 1'b1;
    webAddr <= dvp_pkg::OFS_MASK; webData <= {16'(PIX), 16'(PIX)}; webWr <= 1'b1;
    @(posedge clock);
    wrEn <= 1'b0; webWr <= 1'b0;
    rd(dvp_pkg::OFS_MASK, v); check(v, {16'(PIX), 16'(PIX)});
    rd(dvp_pkg::OFS_CTRL, v); check(v, 32'h1);
    cfg = dvp_pkg::CFG_DEFAULT; cfg.maskL = 9'(PIX); cfg.maskR = 9'(PIX);
    wr(dvp_pkg::OFS_SAVE, 32'h1);
    for (n = 0; n < 20 && nvWrite !== 1'b1; n++) @(posedge clock);
    check(nvWData, 32'(cfg));
    waitRun();
    wr(dvp_pkg::OFS_CTRL, 32'h3);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    waitRun();
    rd(dvp_pkg::OFS_CTRL, v); check(v, 32'h1);
    rd(dvp_pkg::OFS_MASK, v); check(v, {16'(PIX), 16'(PIX)});
    // Boot cycle still measures with the default window
    repeat (3 * DIV) @(posedge clock);
    getOut(1'b1); check(d, 32'(VAL0 / dvp_pkg::AVG_SHORT));
    getOut(1'b1); check(d, 32'((VAL0 + VAL) / dvp_pkg::AVG_SHORT));
    wr(dvp_pkg::OFS_CTRL, 32'h3);
    for (n = 0; n < 8 && d !== 16'(VAL); n++) getOut(1'b1);
    check(d, 32'(VAL));
    getOut(1'b1); check(d, 32'(VAL));
    check(32'(tGap), 32'(DIV));
    rd(dvp_pkg::OFS_LAST, v); check(v, 32'(VAL));
    @(posedge clock);
    outReady <= 1'b0;
    repeat (DIV + 200) @(posedge clock);
    check(outValid, 32'h1);
    check(outData, 32'(VAL));
    outReady <= 1'b1;
    getOut(1'b1); check(d, 32'(VAL));
    wr(dvp_pkg::OFS_MASK, {16'd10, 16'd10});
    wr(dvp_pkg::OFS_CTRL, 32'h7);
    n = 0;
    repeat (5) begin
      getOut(1'b0);
      if (got) n++;
    end
    check(n, 32'd4);
    conclude();
  end
endmodule : tb_dvp_top
